/* File: dv/umsa_lbus_host.sv */
`timescale 1ns/10ps
`default_nettype none
module umsa_lbus_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [2:0] go_fc,
  input wire logic [31:0] go_addr,
  input wire logic go_wr,
  input wire logic [1:0] go_slow,
  output logic done,
  output logic [2:0] res,
  output logic [31:0] res_pa,
  output logic res_glue,
  output logic res_xcvr,
  output logic res_pblk,
  output logic [31:0] logical_address,
  output logic [2:0] function_code,
  output logic logical_address_strobe_n,
  output logic read_write,
  input wire logic [31:0] physical_address,
  input wire logic physical_address_strobe_n,
  input wire logic cpu_space_strobe_n,
  input wire logic own_ack_n,
  input wire logic bus_error_signal_n,
  input wire logic logical_bus_relinquish_n
);
  logic [1:0] st_q;
  logic [1:0] wait_q;
  logic cop_sel;
  logic term;
  logic ldev;
  assign ldev = function_code[2] && function_code != 3'h7 &&
    logical_address[31:16] == 16'h000A;
  assign cop_sel = function_code == 3'h7 && logical_address[19:13] == 7'h12;
  assign term = !(physical_address_strobe_n && cpu_space_strobe_n &&
    own_ack_n && bus_error_signal_n);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= 2'h0;
      wait_q <= 2'h0;
      done <= 1'b1;
      res <= 3'h0;
      res_pa <= 32'h0;
      res_glue <= 1'b0;
      res_xcvr <= 1'b0;
      res_pblk <= 1'b1;
      logical_address <= 32'h0;
      function_code <= 3'h0;
      logical_address_strobe_n <= 1'b1;
      read_write <= 1'b1;
    end else begin
      case (st_q)
        2'h0: if (go) begin
          done <= 1'b0;
          logical_address <= go_addr;
          function_code <= go_fc;
          read_write <= ~go_wr;
          wait_q <= go_slow;
          logical_address_strobe_n <= 1'b0;
          st_q <= 2'h1;
        end
        2'h1: if (term) begin
          res <= !own_ack_n ? 3'h2 : !logical_bus_relinquish_n ? 3'h4 :
            !bus_error_signal_n ? 3'h3 : !cpu_space_strobe_n ? 3'h1 : 3'h0;
          res_pa <= physical_address;
          res_glue <= cpu_space_strobe_n | cop_sel;
          // transceivers on only with a strobe
          res_xcvr <= !(physical_address_strobe_n && cpu_space_strobe_n);
          res_pblk <= physical_address_strobe_n | ldev;
          st_q <= 2'h2;
        end
        2'h2: if (wait_q == 2'h0) begin
          logical_address_strobe_n <= 1'b1;
          logical_address <= ~logical_address;
          st_q <= 2'h3;
        end else begin
          wait_q <= wait_q - 2'h1;
        end
        default: begin
          done <= 1'b1;
          st_q <= 2'h0;
        end
      endcase
    end
  end
endmodule // umsa_lbus_host
`default_nettype wire

/* File: dv/umsa_unity_access_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module umsa_unity_access_asserts #(
  parameter int PAGE_SHIFT = 12,
  parameter int CACHE_ENTRIES = 8,
  parameter logic [2:0] OWN_COPROC_ID = 3'h0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [31:0] logical_address,
  input wire logic [2:0] function_code,
  input wire logic logical_address_strobe_n,
  input wire logic [31:0] physical_address,
  input wire logic physical_address_strobe_n,
  input wire logic cpu_space_strobe_n,
  input wire logic own_ack_n,
  input wire logic bus_error_signal_n,
  input wire logic halt_n,
  input wire logic logical_bus_relinquish_n
);
  logic quiet;
  assign quiet = physical_address_strobe_n & cpu_space_strobe_n &
    own_ack_n & bus_error_signal_n;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_take;
    ce && $fell(logical_address_strobe_n);
  endsequence
  sequence s_release;
    ce && $rose(logical_address_strobe_n);
  endsequence
  a_cpu_unity:
  assert property ($fell(cpu_space_strobe_n) |->
    physical_address == $past(logical_address))
    else $error("cpu space address altered");
  a_cpu_no_cache:
  assert property (s_take ##0 function_code == umsa_pkg::UMSA_FC_CPU
    |=> logical_bus_relinquish_n && halt_n)
    else $error("cpu space cycle retried");
  a_page_unity:
  assert property ($fell(physical_address_strobe_n) |->
    physical_address == $past(logical_address))
    else $error("unity address altered");
  a_cpu_no_term:
  assert property (!cpu_space_strobe_n |-> bus_error_signal_n && own_ack_n)
    else $error("cpu space cycle terminated");
  a_own_decode:
  assert property ($fell(own_ack_n) |->
    $past(function_code) == umsa_pkg::UMSA_FC_CPU &&
    $past(logical_address[19:16]) == umsa_pkg::UMSA_CPU_TYPE_COPROC &&
    $past(logical_address[15:13]) == OWN_COPROC_ID)
    else $error("own acknowledge without own select");
  a_cpu_strobe_src:
  assert property ($fell(cpu_space_strobe_n) |->
    $past(function_code) == umsa_pkg::UMSA_FC_CPU &&
    physical_address_strobe_n)
    else $error("cpu strobe on wrong space");
  a_release_quiet:
  assert property (s_release |=> quiet && halt_n && logical_bus_relinquish_n)
    else $error("outputs held after strobe release");
  a_prompt_answer:
  assert property (s_take |=> !quiet)
    else $error("cycle not answered in time");
  a_retry_trio:
  assert property ($fell(logical_bus_relinquish_n) |->
    !bus_error_signal_n && !halt_n && physical_address_strobe_n)
    else $error("retry without error and halt");
endmodule // umsa_unity_access_asserts
bind umsa_unity_access umsa_unity_access_asserts #(
  .PAGE_SHIFT(PAGE_SHIFT),
  .CACHE_ENTRIES(CACHE_ENTRIES),
  .OWN_COPROC_ID(OWN_COPROC_ID)
) u_chk (.*);
`default_nettype wire

/* File: dv/umsa_unity_access_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module umsa_unity_access_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = umsa_pkg::UMSA_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic [2:0] go_fc = 3'h0;
  logic [31:0] go_addr = 32'h0;
  logic go_wr = 1'b0;
  logic [1:0] go_slow = 2'h0;
  wire logic hready;
  logic hreadyout, hresp, done, res_glue, read_write, halt_n;
  logic logical_address_strobe_n, physical_address_strobe_n;
  logic cpu_space_strobe_n, own_ack_n, bus_error_signal_n;
  logic logical_bus_relinquish_n;
  logic res_xcvr, res_pblk;
  logic [2:0] last_e = 3'h0;
  logic [31:0] last_fa = 32'h0;
  logic [2:0] res, function_code, f;
  logic [31:0] hrdata, res_pa, logical_address, physical_address, a;
  logic [31:0] sh_srp = 32'h0;
  logic [31:0] sh_crp = 32'h0;
  logic sh_en = 1'b0;
  logic sh_sre = 1'b0;
  logic [19:0] tags[$];
  int seed = 32'heba6;
  int misses = 0;
  int bad_count = 0;
  int num_checks = 0;
  assign hready = hreadyout;
  always #20 clock = ~clock;
  umsa_unity_access u_dut (.*);
  umsa_lbus_host u_host (.*);
  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: answer %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up();
    bad_count++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask
  task automatic ahb_wait();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) give_up();
  endtask
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= umsa_pkg::UMSA_HTRANS_NONSEQ;
    ahb_wait();
    htrans <= 2'h0;
    hwdata <= d;
    ahb_wait();
    if (!w) chk_word(hrdata, d);
  endtask
  // Answer codes: 0 pass, 1 cpu, 2 own, 3 error, 4 retry
  function automatic logic [2:0] exp_res(input logic [2:0] fc,
      input logic [31:0] la, input logic w);
    logic [31:0] r;
    r = (fc[umsa_pkg::UMSA_FC_SUPER_BIT] && sh_sre) ? sh_srp : sh_crp;
    if (!sh_en) return 3'h0;
    if (fc == umsa_pkg::UMSA_FC_CPU) return la[19:13] == 7'h10 ? 3'h2 : 3'h1;
    if (r[1:0] != umsa_pkg::UMSA_DT_PAGE) return 3'h3;
    if (!(la[31:12] inside {tags})) return 3'h4;
    return (r[umsa_pkg::UMSA_RP_WP_BIT] && w) ? 3'h3 : 3'h0;
  endfunction
  // Logical device: supervisor, not cpu space, page group 000A
  function automatic logic ldev_sel(input logic [2:0] fc,
      input logic [31:0] la);
    return fc[2] && fc != umsa_pkg::UMSA_FC_CPU && la[31:16] == 16'h000A;
  endfunction
  task automatic lcyc(input logic [2:0] fc, input logic [31:0] la,
      input logic w);
    logic [2:0] e;
    int n;
    e = exp_res(fc, la, w);
    go <= 1'b1;
    go_fc <= fc;
    go_addr <= la;
    go_wr <= w;
    go_slow <= 2'($random(seed));
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (done !== 1'b1 && n < 50);
    if (n >= 50) give_up();
    chk_code(res, e);
    if (e < 3'h2) chk_word(res_pa, la);
    chk_word({31'h0, res_xcvr}, {31'h0, e < 3'h2});
    chk_word({31'h0, res_pblk}, {31'h0, e != 3'h0 || ldev_sel(fc, la)});
    last_e = e;
    if (e > 3'h2) last_fa = la;
    if (e == 3'h4) begin
      tags.push_back(la[31:12]);
      misses++;
    end
    @(posedge clock);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    ahb(1'b1, 8'h24, 32'hFFFFFFFF);
    ahb(1'b1, umsa_pkg::UMSA_OFS_MISS_CNT, 32'h5);
    for (int i = 0; i < 10; i++) begin
      ahb(1'b0, 8'(i * 4), 32'h0);
    end
    lcyc(3'h5, 32'h12345678, 1'b1);
    ahb(1'b1, umsa_pkg::UMSA_OFS_CTRL, 32'h1);
    sh_en = 1'b1;
    ahb(1'b1, umsa_pkg::UMSA_OFS_SRP_HI, 32'h201);
    sh_srp = 32'h201;
    lcyc(3'h1, 32'h00150000, 1'b1);
    lcyc(3'h5, 32'h000A0000, 1'b0);
    lcyc(3'h7, 32'h00020000, 1'b1);
    lcyc(3'h7, 32'h00024000, 1'b0);
    chk_word({31'h0, res_glue}, 32'h1);
    ce <= 1'b0;
    fork
      begin
        repeat (4) @(posedge clock);
        ce <= 1'b1;
      end
    join_none
    lcyc(3'h7, 32'h00031000, 1'b1);
    chk_word({31'h0, res_glue}, 32'h0);
    ahb(1'b1, umsa_pkg::UMSA_OFS_CTRL, 32'h3);
    sh_sre = 1'b1;
    ahb(1'b1, umsa_pkg::UMSA_OFS_CRP_HI, 32'h205);
    sh_crp = 32'h205;
    lcyc(3'h5, 32'h000A0000, 1'b1);
    lcyc(3'h5, 32'h000A0FFC, 1'b1);
    for (int i = 0; i < 60; i++) begin
      if (i == 30) begin
        ahb(1'b1, umsa_pkg::UMSA_OFS_CTRL, 32'h7);
        tags.delete();
        ahb(1'b0, umsa_pkg::UMSA_OFS_CTRL, 32'h3);
      end
      f = 3'($random(seed));
      a = {f[2] ? 18'h00028 : 18'h00054, 2'($random(seed)),
        12'($random(seed))};
      lcyc(f, a, 1'($random(seed)));
    end
    ahb(1'b0, umsa_pkg::UMSA_OFS_MISS_CNT, 32'(misses));
    ahb(1'b0, umsa_pkg::UMSA_OFS_STATUS,
      {30'h0, last_e == 3'h3, last_e == 3'h4});
    ahb(1'b0, umsa_pkg::UMSA_OFS_FAULT_ADDR, last_fa);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    ahb(1'b0, umsa_pkg::UMSA_OFS_CTRL, 32'h0);
    wrap_up();
  end
endmodule // umsa_unity_access_tb_top
`default_nettype wire

/* File: hdl/umsa_pkg.sv */
package umsa_pkg;
  // Register byte offsets
  localparam logic [7:0] UMSA_OFS_CTRL = 8'h00;
  localparam logic [7:0] UMSA_OFS_SRP_HI = 8'h04;
  localparam logic [7:0] UMSA_OFS_SRP_LO = 8'h08;
  localparam logic [7:0] UMSA_OFS_CRP_HI = 8'h0C;
  localparam logic [7:0] UMSA_OFS_CRP_LO = 8'h10;
  localparam logic [7:0] UMSA_OFS_STATUS = 8'h14;
  localparam logic [7:0] UMSA_OFS_MISS_CNT = 8'h18;
  localparam logic [7:0] UMSA_OFS_FAULT_ADDR = 8'h1C;
  // Control fields
  localparam int UMSA_CTRL_ENABLE_BIT = 0;
  localparam int UMSA_CTRL_SRE_BIT = 1;
  localparam int UMSA_CTRL_FLUSH_BIT = 2;
  localparam logic [1:0] UMSA_CTRL_RESET = 2'h0;
  // Root pointer upper word fields
  localparam int UMSA_RP_DT_LSB = 0;
  localparam int UMSA_RP_WP_BIT = 2;
  localparam int UMSA_RP_SG_BIT = 9;
  localparam logic [1:0] UMSA_DT_PAGE = 2'h1;
  localparam logic [31:0] UMSA_RP_RESET = 32'h00000000;
  // Status fields
  localparam int UMSA_ST_MISS_BIT = 0;
  localparam int UMSA_ST_ERR_BIT = 1;
  localparam int UMSA_ST_BUSY_BIT = 2;
  // Logical bus codes
  localparam logic [2:0] UMSA_FC_CPU = 3'h7;
  localparam int UMSA_FC_SUPER_BIT = 2;
  localparam logic [3:0] UMSA_CPU_TYPE_COPROC = 4'h2;
  // AHB-Lite encodings
  localparam logic [1:0] UMSA_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] UMSA_HSIZE_WORD = 3'h2;
endpackage

/* File: hdl/umsa_unity_access.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: CPU space: physical equals logical, unchecked
// R2: CPU space bypasses cache, no entries
// R3: Page-type root: unity map, checks, entries
// R4: CPU space never terminated, own registers excepted
// R5: CPU space validated by cpu space strobe
// R6: Glue negates cpu strobe for coprocessor select
// R7: Coprocessor select decoded from logical address
// R8: Glue floats transceivers unless strobe asserted
// R9: Every logical cycle monitored, no suppression
// R10: Logical devices honour error and retry
// R11: Synchronous cycles terminated in time
// R12: Software loads supervisor root, sets enable
// R13: Enable set: supervisor uses supervisor root; code uses it only when sre_q is also set, else crp_hi_q
// R14: Glue blocks physical strobe for logical device
// R15: Unity page needs resident cache entry
// R16: Miss: error, halt, relinquish; build entry
module umsa_unity_access #(
  parameter int PAGE_SHIFT = 12,
  parameter int CACHE_ENTRIES = 8,
  parameter logic [2:0] OWN_COPROC_ID = 3'h0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [31:0] logical_address,
  input wire logic [2:0] function_code,
  input wire logic logical_address_strobe_n,
  input wire logic read_write,
  output logic [31:0] physical_address,
  output logic physical_address_strobe_n,
  output logic cpu_space_strobe_n,
  output logic own_ack_n,
  output logic bus_error_signal_n,
  output logic halt_n,
  output logic logical_bus_relinquish_n
);
  localparam int TAG_W = 32 - PAGE_SHIFT;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_PASS = 6'b000010,
    ST_CPU = 6'b000100,
    ST_OWN = 6'b001000,
    ST_ERR = 6'b010000,
    ST_RETRY = 6'b100000
  } umsa_state_e;

  umsa_state_e state_q;
  umsa_state_e state_d;

  // Register file
  logic enable_q;
  logic sre_q;
  logic [31:0] srp_hi_q;
  logic [31:0] srp_lo_q;
  logic [31:0] crp_hi_q;
  logic [31:0] crp_lo_q;
  logic miss_flag_q;
  logic err_flag_q;
  logic [31:0] miss_cnt_q;
  logic [31:0] fault_addr_q;
  logic flush_q;

  // Bus slave
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic addr_phase;

  // Cycle capture for the fill
  logic fill_q;
  logic [TAG_W-1:0] fill_tag_q;
  logic fill_super_q;
  logic fill_global_q;
  logic fill_wp_q;

  logic cycle_start;
  logic cycle_end;
  logic is_cpu;
  logic is_super;
  logic is_own;
  logic [31:0] root_hi;
  logic root_unity;
  logic cache_hit;
  logic cache_wp;
  logic [TAG_W-1:0] look_tag;

  logic [31:0] pa_q;
  logic pas_n_q;
  logic cli_n_q;
  logic ack_n_q;
  logic bus_error_signal_n_q;
  logic halt_n_q;
  logic logical_bus_relinquish_n_q;

  function automatic logic [31:0] reg_read(input logic [7:0] ofs,
      input logic en, input logic supervisor_root_enable, input logic [31:0] shi,
      input logic [31:0] slo, input logic [31:0] chi,
      input logic [31:0] clo, input logic [2:0] st,
      input logic [31:0] cnt, input logic [31:0] fa);
    logic [31:0] v;
    v = 32'h00000000;
    case (ofs)
      umsa_pkg::UMSA_OFS_CTRL: begin
        v[umsa_pkg::UMSA_CTRL_ENABLE_BIT] = en;
        v[umsa_pkg::UMSA_CTRL_SRE_BIT] = supervisor_root_enable;
      end
      umsa_pkg::UMSA_OFS_SRP_HI: v = shi;
      umsa_pkg::UMSA_OFS_SRP_LO: v = slo;
      umsa_pkg::UMSA_OFS_CRP_HI: v = chi;
      umsa_pkg::UMSA_OFS_CRP_LO: v = clo;
      umsa_pkg::UMSA_OFS_STATUS: v[2:0] = st;
      umsa_pkg::UMSA_OFS_MISS_CNT: v = cnt;
      umsa_pkg::UMSA_OFS_FAULT_ADDR: v = fa;
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  // AHB-Lite: zero wait state, always OKAY
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (ce) begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h00000000;
    end else if (ce && addr_phase && !hwrite) begin
      hrdata_q <= reg_read({haddr[7:2], 2'b00}, enable_q, sre_q, srp_hi_q,
                           srp_lo_q, crp_hi_q, crp_lo_q,
                           {state_q != ST_IDLE, err_flag_q, miss_flag_q},
                           miss_cnt_q, fault_addr_q);
    end
  end

  // Control and root pointers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_q <= umsa_pkg::UMSA_CTRL_RESET[umsa_pkg::UMSA_CTRL_ENABLE_BIT];
      sre_q <= umsa_pkg::UMSA_CTRL_RESET[umsa_pkg::UMSA_CTRL_SRE_BIT];
      flush_q <= 1'b0;
      srp_hi_q <= umsa_pkg::UMSA_RP_RESET;
      srp_lo_q <= umsa_pkg::UMSA_RP_RESET;
      crp_hi_q <= umsa_pkg::UMSA_RP_RESET;
      crp_lo_q <= umsa_pkg::UMSA_RP_RESET;
    end else if (ce) begin
      flush_q <= 1'b0;
      if (wr_pend_q) begin
        case (wr_addr_q)
          umsa_pkg::UMSA_OFS_CTRL: begin
            enable_q <= hwdata[umsa_pkg::UMSA_CTRL_ENABLE_BIT];
            // R12: enable bit written
            sre_q <= hwdata[umsa_pkg::UMSA_CTRL_SRE_BIT];
            flush_q <= hwdata[umsa_pkg::UMSA_CTRL_FLUSH_BIT];
          end
          umsa_pkg::UMSA_OFS_SRP_HI: srp_hi_q <= hwdata;
          umsa_pkg::UMSA_OFS_SRP_LO: srp_lo_q <= hwdata;
          umsa_pkg::UMSA_OFS_CRP_HI: crp_hi_q <= hwdata;
          umsa_pkg::UMSA_OFS_CRP_LO: crp_lo_q <= hwdata;
          default: ;
        endcase
      end
    end
  end

  // Cycle decode
  // R9: every strobe starts a decision
  assign cycle_start = (state_q == ST_IDLE) && !logical_address_strobe_n;
  assign cycle_end = logical_address_strobe_n;
  assign is_cpu = (function_code == umsa_pkg::UMSA_FC_CPU);
  assign is_super = function_code[umsa_pkg::UMSA_FC_SUPER_BIT];
  // R4: own register set inside CPU space
  assign is_own = is_cpu &&
      (logical_address[19:16] == umsa_pkg::UMSA_CPU_TYPE_COPROC) &&
      (logical_address[15:13] == OWN_COPROC_ID);
  // R13: supervisor root selected by supervisor root enable (sre_q)
  assign root_hi = (is_super && sre_q) ? srp_hi_q : crp_hi_q;
  // R3: page descriptor type means unity
  assign root_unity = (root_hi[umsa_pkg::UMSA_RP_DT_LSB +: 2] ==
                       umsa_pkg::UMSA_DT_PAGE);
  assign look_tag = logical_address[31:PAGE_SHIFT];

  umsa_xcache #(
    .ENTRIES(CACHE_ENTRIES),
    .TAG_W(TAG_W)
  ) u_cache (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .flush(flush_q),
    .look_tag(look_tag),
    .look_super(is_super),
    .hit(cache_hit),
    .hit_wp(cache_wp),
    .fill(fill_q),
    .fill_tag(fill_tag_q),
    .fill_super(fill_super_q),
    .fill_global(fill_global_q),
    .fill_wp(fill_wp_q)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cycle_start) begin
          if (!enable_q) begin
            state_d = ST_PASS;
          end else if (is_own) begin
            state_d = ST_OWN;
          // R2: no cache lookup in CPU space
          end else if (is_cpu) begin
            state_d = ST_CPU;
          end else if (!root_unity) begin
            state_d = ST_ERR;
          // R15: resident entry required
          end else if (!cache_hit) begin
            state_d = ST_RETRY;
          // R3: protection still checked
          end else if (cache_wp && !read_write) begin
            state_d = ST_ERR;
          end else begin
            state_d = ST_PASS;
          end
        end
      end
      ST_PASS, ST_CPU, ST_OWN, ST_ERR, ST_RETRY: begin
        if (cycle_end) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // R11: strobes follow one edge after the cycle starts
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pas_n_q <= 1'b1;
      cli_n_q <= 1'b1;
      ack_n_q <= 1'b1;
      bus_error_signal_n_q <= 1'b1;
      halt_n_q <= 1'b1;
      logical_bus_relinquish_n_q <= 1'b1;
    end else if (ce) begin
      pas_n_q <= !(state_d == ST_PASS);
      // R5: CPU space uses its own strobe
      cli_n_q <= !(state_d == ST_CPU);
      ack_n_q <= !(state_d == ST_OWN);
      // R16: retry drives all three together
      bus_error_signal_n_q <= !((state_d == ST_ERR) || (state_d == ST_RETRY));
      halt_n_q <= !(state_d == ST_RETRY);
      logical_bus_relinquish_n_q <= !(state_d == ST_RETRY);
    end
  end

  // R1: unity address out, no checks on CPU space
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pa_q <= 32'h00000000;
    end else if (ce && cycle_start) begin
      pa_q <= logical_address;
    end
  end

  // R16: one-to-one entry built once the retried cycle ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fill_q <= 1'b0;
      fill_tag_q <= '0;
      fill_super_q <= 1'b0;
      fill_global_q <= 1'b0;
      fill_wp_q <= 1'b0;
    end else if (ce) begin
      fill_q <= (state_q == ST_RETRY) && cycle_end;
      if (cycle_start) begin
        fill_tag_q <= look_tag;
        fill_super_q <= is_super;
        fill_global_q <= root_hi[umsa_pkg::UMSA_RP_SG_BIT];
        fill_wp_q <= root_hi[umsa_pkg::UMSA_RP_WP_BIT];
      end
    end
  end

  // Status, sticky until the next decided cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      miss_flag_q <= 1'b0;
      err_flag_q <= 1'b0;
      miss_cnt_q <= 32'h00000000;
      fault_addr_q <= 32'h00000000;
    end else if (ce && cycle_start) begin
      miss_flag_q <= (state_d == ST_RETRY);
      err_flag_q <= (state_d == ST_ERR);
      if (state_d == ST_RETRY) begin
        miss_cnt_q <= miss_cnt_q + 32'h00000001;
      end
      if ((state_d == ST_RETRY) || (state_d == ST_ERR)) begin
        fault_addr_q <= logical_address;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign physical_address = pa_q;
  assign physical_address_strobe_n = pas_n_q;
  assign cpu_space_strobe_n = cli_n_q;
  assign own_ack_n = ack_n_q;
  assign bus_error_signal_n = bus_error_signal_n_q;
  assign halt_n = halt_n_q;
  assign logical_bus_relinquish_n = logical_bus_relinquish_n_q;
endmodule // umsa_unity_access
`default_nettype wire

/* File: hdl/umsa_xcache.sv */
`timescale 1ns/10ps
`default_nettype none
module umsa_xcache #(
  parameter int ENTRIES = 8,
  parameter int TAG_W = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  input wire logic [TAG_W-1:0] look_tag,
  input wire logic look_super,
  output logic hit,
  output logic hit_wp,
  input wire logic fill,
  input wire logic [TAG_W-1:0] fill_tag,
  input wire logic fill_super,
  input wire logic fill_global,
  input wire logic fill_wp
);
  localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  logic [ENTRIES-1:0] valid_q;
  logic [TAG_W-1:0] tag_q [ENTRIES];
  logic [ENTRIES-1:0] super_q;
  logic [ENTRIES-1:0] global_q;
  logic [ENTRIES-1:0] wp_q;
  logic [ENTRIES-1:0] match;
  logic [PW-1:0] victim_q;

  // Global entries answer either privilege
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_match
      assign match[gi] = valid_q[gi] && (tag_q[gi] == look_tag) &&
                         (global_q[gi] || (super_q[gi] == look_super));
    end
  endgenerate

  assign hit = |match;
  assign hit_wp = |(match & wp_q);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      valid_q <= '0;
    end else if (ce) begin
      if (flush) begin
        valid_q <= '0;
      end
      // A fill in the flush cycle survives
      if (fill) begin
        valid_q[victim_q] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (ce && fill) begin
      tag_q[victim_q] <= fill_tag;
      super_q[victim_q] <= fill_super;
      global_q[victim_q] <= fill_global;
      wp_q[victim_q] <= fill_wp;
    end
  end

  // Round-robin replacement
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      victim_q <= '0;
    end else if (ce && fill) begin
      if (victim_q == PW'(ENTRIES - 1)) begin
        victim_q <= '0;
      end else begin
        victim_q <= victim_q + PW'(1);
      end
    end
  end
endmodule // umsa_xcache
`default_nettype wire
